// ---- hw/tcsup_top.sv ----
// Trip circuit supervisor with AXI4-Lite register access.
`timescale 1ns/1ns
module tcsup_top #(
   parameter int MS_CYCLES = tcsup_pkg::TCSUP_MS_CYCLES
) (
   input  wire logic        i_core_clk,    // 125 MHz clock.
   input  wire logic        i_rst,         // Synchronous reset, high.
   input  wire logic        i_breaker_open,   // Breaker open contact.
   input  wire logic        i_breaker_closed, // Breaker closed contact.
   input  wire logic        i_supervision_input_a, // Supervision input.
   input  wire logic        i_supervision_input_b, // Second input, mode 1.
   output logic             o_wrong_position_alarm, // Alarm to output.
   output logic             o_irq,         // Level interrupt.
   input  wire logic [7:0]  i_awaddr,      // Write address.
   input  wire logic        i_awvalid,     // Write address valid.
   output logic             o_awready,     // Write address ready.
   input  wire logic [31:0] i_wdata,       // Write data.
   input  wire logic [3:0]  i_wstrb,       // Write strobes.
   input  wire logic        i_wvalid,      // Write data valid.
   output logic             o_wready,      // Write data ready.
   output logic [1:0]       o_bresp,       // Write response.
   output logic             o_bvalid,      // Write response valid.
   input  wire logic        i_bready,      // Write response ready.
   input  wire logic [7:0]  i_araddr,      // Read address.
   input  wire logic        i_arvalid,     // Read address valid.
   output logic             o_arready,     // Read address ready.
   output logic [31:0]      o_rdata,       // Read data.
   output logic [1:0]       o_rresp,       // Read response.
   output logic             o_rvalid,      // Read data valid.
   input  wire logic        i_rready       // Read data ready.
);
   import tcsup_pkg::*;

   // ******************************************************************
   // Helper functions
   // ******************************************************************

   // Applies byte strobes to a 32-bit word.
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Limits a delay to its maximum.
   function automatic logic [15:0] clamp(input logic [15:0] v,
                                         input logic [15:0] mx);
      return (v > mx) ? mx : v;
   endfunction

   // Converts the two-bit field into a one-hot mode.
   function automatic tcsup_mode_e to_mode(input logic [1:0] f);
      tcsup_mode_e m;
      m = TCSUP_M1;
      case (f)
         2'h0: m = TCSUP_M1;
         2'h1: m = TCSUP_M2;
         2'h2: m = TCSUP_M3;
         default: m = TCSUP_M4;
      endcase
      return m;
   endfunction

   // ******************************************************************
   // Registers and state
   // ******************************************************************
   logic        en_q, en_d;
   logic        permit_q, permit_d;
   logic [1:0]  mode_f_q, mode_f_d;
   logic [15:0] ll_dly_q, ll_dly_d;
   logic [15:0] hh_dly_q, hh_dly_d;
   logic [1:0]  irq_st_q, irq_st_d;
   logic [1:0]  irq_msk_q, irq_msk_d;
   logic [31:0] count_q, count_d;
   logic [16:0] tick_cnt_q, tick_cnt_d;
   logic        tick_q, tick_d;
   logic [15:0] ll_ms_q, ll_ms_d;
   logic [15:0] hh_ms_q, hh_ms_d;
   logic        alarm_q, alarm_d;
   logic        irq_q, irq_d;

   logic        aw_got_q, aw_got_d;
   logic        w_got_q, w_got_d;
   logic [7:0]  awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0]  wstrb_q, wstrb_d;
   logic        bvalid_q, bvalid_d;
   logic [1:0]  bresp_q, bresp_d;
   logic        rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  rresp_q, rresp_d;

   tcsup_mode_e mode;
   logic        ll_cond;
   logic        hh_cond;
   logic        wr_fire;
   logic        rd_fire;
   logic        rd_stat_clr;
   logic        rise;
   logic        fall;
   logic [31:0] wr_word;

   // ******************************************************************
   // Pattern evaluation
   // ******************************************************************

   // Selects which invalid pattern is present in the chosen mode.
   always_comb begin
      mode    = to_mode(mode_f_q);
      ll_cond = 1'b0;
      hh_cond = 1'b0;
      case (mode)
         TCSUP_M1: begin
            // Exactly one high is valid.
            ll_cond = ~i_supervision_input_a & ~i_supervision_input_b;
            hh_cond = i_supervision_input_a & i_supervision_input_b
                      & ~permit_q;
         end
         TCSUP_M2: begin
            ll_cond = ~i_breaker_open & ~i_supervision_input_a;
         end
         TCSUP_M3: begin
            ll_cond = ~i_supervision_input_a;
         end
         TCSUP_M4: begin
            // Open alone means open; closed or unknown is supervised.
            ll_cond = ~(i_breaker_open & ~i_breaker_closed)
                      & ~i_supervision_input_a;
         end
         default: begin
            ll_cond = 1'b0;
         end
      endcase
   end

   // ******************************************************************
   // Millisecond timers and alarm
   // ******************************************************************

   // Counts milliseconds in each invalid pattern and raises the alarm.
   always_comb begin
      tick_cnt_d = tick_cnt_q + 17'd1;
      tick_d     = 1'b0;
      if (tick_cnt_q == 17'(MS_CYCLES - 1)) begin
         tick_cnt_d = '0;
         tick_d     = 1'b1;
      end
      ll_ms_d = ll_ms_q;
      hh_ms_d = hh_ms_q;
      alarm_d = 1'b0;
      if (!en_q) begin
         ll_ms_d = '0;
         hh_ms_d = '0;
      end else begin
         // Separate timers per pattern.
         if (!ll_cond) begin
            ll_ms_d = '0;
         end else if (tick_q && ll_ms_q <= ll_dly_q) begin
            ll_ms_d = ll_ms_q + 16'd1;
         end
         if (!hh_cond) begin
            hh_ms_d = '0;
         end else if (tick_q && hh_ms_q <= hh_dly_q) begin
            hh_ms_d = hh_ms_q + 16'd1;
         end
         // First tick ends a partial ms; alarm after dly+1 ticks, or at once when dly is 0.
         alarm_d = (ll_cond && (ll_ms_q > ll_dly_q || ll_dly_q == '0)) ||
                   (hh_cond && (hh_ms_q > hh_dly_q || hh_dly_q == '0));
      end
   end

   assign rise = alarm_d & ~alarm_q;
   assign fall = ~alarm_d & alarm_q;

   // Counts alarm assertions, wrapping at full scale.
   always_comb begin
      count_d = count_q;
      if (rise) begin
         count_d = count_q + 32'd1;
      end
   end

   // ******************************************************************
   // AXI4-Lite slave
   // ******************************************************************
   assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
   assign rd_fire = i_arvalid && o_arready;
   assign rd_stat_clr = rd_fire && (i_araddr == TCSUP_IRQST_OFS);

   // Captures address and data in any order and answers writes.
   always_comb begin
      aw_got_d = aw_got_q;
      w_got_d  = w_got_q;
      awaddr_d = awaddr_q;
      wdata_d  = wdata_q;
      wstrb_d  = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d  = bresp_q;
      if (i_awvalid && o_awready) begin
         aw_got_d = 1'b1;
         awaddr_d = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         w_got_d = 1'b1;
         wdata_d = i_wdata;
         wstrb_d = i_wstrb;
      end
      if (wr_fire) begin
         aw_got_d = 1'b0;
         w_got_d  = 1'b0;
         bvalid_d = 1'b1;
         bresp_d  = TCSUP_RESP_OKAY;
         if (awaddr_q != TCSUP_CTRL_OFS && awaddr_q != TCSUP_LLDLY_OFS &&
             awaddr_q != TCSUP_HHDLY_OFS && awaddr_q != TCSUP_IRQMSK_OFS &&
             awaddr_q != TCSUP_STAT_OFS && awaddr_q != TCSUP_COUNT_OFS &&
             awaddr_q != TCSUP_IRQST_OFS) begin
            bresp_d = TCSUP_RESP_SLVERR;
         end
      end else if (bvalid_q && i_bready) begin
         bvalid_d = 1'b0;
      end
   end

   // Applies writes to control, delay and mask registers.
   always_comb begin
      en_d      = en_q;
      permit_d  = permit_q;
      mode_f_d  = mode_f_q;
      ll_dly_d  = ll_dly_q;
      hh_dly_d  = hh_dly_q;
      irq_msk_d = irq_msk_q;
      wr_word   = '0;
      if (wr_fire) begin
         if (awaddr_q == TCSUP_CTRL_OFS) begin
            wr_word  = merge({28'h0, permit_q, mode_f_q, en_q},
                             wdata_q, wstrb_q);
            en_d     = wr_word[TCSUP_CTRL_EN_BIT];
            mode_f_d = wr_word[TCSUP_CTRL_MODE_LSB +: 2];
            permit_d = wr_word[TCSUP_CTRL_PERMIT_BIT];
         end else if (awaddr_q == TCSUP_LLDLY_OFS) begin
            wr_word  = merge({16'h0, ll_dly_q}, wdata_q, wstrb_q);
            ll_dly_d = clamp(wr_word[15:0], TCSUP_LL_MAX_MS);
         end else if (awaddr_q == TCSUP_HHDLY_OFS) begin
            wr_word  = merge({16'h0, hh_dly_q}, wdata_q, wstrb_q);
            hh_dly_d = clamp(wr_word[15:0], TCSUP_HH_MAX_MS);
         end else if (awaddr_q == TCSUP_IRQMSK_OFS) begin
            wr_word   = merge({30'h0, irq_msk_q}, wdata_q, wstrb_q);
            irq_msk_d = wr_word[1:0];
         end
      end
   end

   // Sticky events; a new event wins over the read that clears.
   always_comb begin
      irq_st_d = rd_stat_clr ? 2'b00 : irq_st_q;
      irq_st_d[TCSUP_IRQ_RISE_BIT] = irq_st_d[TCSUP_IRQ_RISE_BIT] | rise;
      irq_st_d[TCSUP_IRQ_FALL_BIT] = irq_st_d[TCSUP_IRQ_FALL_BIT] | fall;
      irq_d = |(irq_st_d & irq_msk_d);
   end

   // Returns read data one cycle after the address is taken.
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (rd_fire) begin
         rvalid_d = 1'b1;
         rresp_d  = TCSUP_RESP_OKAY;
         rdata_d  = '0;
         if (i_araddr == TCSUP_CTRL_OFS) begin
            rdata_d = {28'h0, permit_q, mode_f_q, en_q};
         end else if (i_araddr == TCSUP_LLDLY_OFS) begin
            rdata_d = {16'h0, ll_dly_q};
         end else if (i_araddr == TCSUP_HHDLY_OFS) begin
            rdata_d = {16'h0, hh_dly_q};
         end else if (i_araddr == TCSUP_STAT_OFS) begin
            rdata_d = {27'h0, i_breaker_closed, i_breaker_open,
                       i_supervision_input_b, i_supervision_input_a,
                       alarm_q};
         end else if (i_araddr == TCSUP_COUNT_OFS) begin
            rdata_d = count_q;
         end else if (i_araddr == TCSUP_IRQST_OFS) begin
            rdata_d = {30'h0, irq_st_q};
         end else if (i_araddr == TCSUP_IRQMSK_OFS) begin
            rdata_d = {30'h0, irq_msk_q};
         end else begin
            rresp_d = TCSUP_RESP_SLVERR;
         end
      end else if (rvalid_q && i_rready) begin
         rvalid_d = 1'b0;
      end
   end

   // ******************************************************************
   // State registers
   // ******************************************************************

   // Registers every group; reset gives defined values.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         en_q       <= 1'b0;
         permit_q   <= 1'b0;
         mode_f_q   <= 2'h0;
         ll_dly_q   <= TCSUP_DLY_DEF_MS;
         hh_dly_q   <= TCSUP_DLY_DEF_MS;
         irq_st_q   <= 2'h0;
         irq_msk_q  <= 2'h0;
         count_q    <= 32'h0;
         tick_cnt_q <= 17'h0;
         tick_q     <= 1'b0;
         ll_ms_q    <= 16'h0;
         hh_ms_q    <= 16'h0;
         alarm_q    <= 1'b0;
         irq_q      <= 1'b0;
         aw_got_q   <= 1'b0;
         w_got_q    <= 1'b0;
         awaddr_q   <= 8'h0;
         wdata_q    <= 32'h0;
         wstrb_q    <= 4'h0;
         bvalid_q   <= 1'b0;
         bresp_q    <= 2'h0;
         rvalid_q   <= 1'b0;
         rdata_q    <= 32'h0;
         rresp_q    <= 2'h0;
      end else begin
         en_q       <= en_d;
         permit_q   <= permit_d;
         mode_f_q   <= mode_f_d;
         ll_dly_q   <= ll_dly_d;
         hh_dly_q   <= hh_dly_d;
         irq_st_q   <= irq_st_d;
         irq_msk_q  <= irq_msk_d;
         count_q    <= count_d;
         tick_cnt_q <= tick_cnt_d;
         tick_q     <= tick_d;
         ll_ms_q    <= ll_ms_d;
         hh_ms_q    <= hh_ms_d;
         alarm_q    <= alarm_d;
         irq_q      <= irq_d;
         aw_got_q   <= aw_got_d;
         w_got_q    <= w_got_d;
         awaddr_q   <= awaddr_d;
         wdata_q    <= wdata_d;
         wstrb_q    <= wstrb_d;
         bvalid_q   <= bvalid_d;
         bresp_q    <= bresp_d;
         rvalid_q   <= rvalid_d;
         rdata_q    <= rdata_d;
         rresp_q    <= rresp_d;
      end
   end

   // Outputs come from flip-flops; the ready outputs are gated from them.
   assign o_wrong_position_alarm = alarm_q;
   assign o_irq     = irq_q;
   assign o_awready = ~aw_got_q & ~bvalid_q;
   assign o_wready  = ~w_got_q & ~bvalid_q;
   assign o_bvalid  = bvalid_q;
   assign o_bresp   = bresp_q;
   assign o_arready = ~rvalid_q;
   assign o_rvalid  = rvalid_q;
   assign o_rdata   = rdata_q;
   assign o_rresp   = rresp_q;

endmodule

// ---- hw/tcsup_pkg.sv ----
// Constants, register map and types for the trip circuit supervisor.
//
// How it works
// - Sample isolated supervision inputs, produce one alarm, drive output and registers.
// - Four selectable wiring modes: two inputs, plus input, resistor, no resistor.
// - Mode 1 pair is valid only when exactly one input reads one.
// - Mode 1 both-low and both-high each have their own delay timer.
// - Mode 1: 01 and 10 keep alarm off; 00 and 11 alarm after delays.
// - Mode 2 alarms after low-low delay only when open and input a are 0.
// - Mode 3 alarms after low-low delay while input a reads 0.
// - Mode 4 never alarms when open alone; else alarms after delay on input a 0.
// - Low-low delay programmable 0 to 60000 ms, default 1000 ms.
// - High-high delay 0 to 10000 ms, default 1000; permit setting suppresses it.
// - Count every rising edge of the alarm; count is readable.
package tcsup_pkg;

   // Register byte offsets.
   localparam logic [7:0] TCSUP_CTRL_OFS   = 8'h00;
   localparam logic [7:0] TCSUP_LLDLY_OFS  = 8'h04;
   localparam logic [7:0] TCSUP_HHDLY_OFS  = 8'h08;
   localparam logic [7:0] TCSUP_STAT_OFS   = 8'h0c;
   localparam logic [7:0] TCSUP_COUNT_OFS  = 8'h10;
   localparam logic [7:0] TCSUP_IRQST_OFS  = 8'h14;
   localparam logic [7:0] TCSUP_IRQMSK_OFS = 8'h18;

   // Control field positions.
   localparam int TCSUP_CTRL_EN_BIT     = 0;
   localparam int TCSUP_CTRL_MODE_LSB   = 1;
   localparam int TCSUP_CTRL_PERMIT_BIT = 3;

   // Delay limits and defaults in milliseconds.
   localparam logic [15:0] TCSUP_LL_MAX_MS = 16'd60000;
   localparam logic [15:0] TCSUP_HH_MAX_MS = 16'd10000;
   localparam logic [15:0] TCSUP_DLY_DEF_MS = 16'd1000;

   // Millisecond tick derived from the 125 MHz clock.
   localparam int TCSUP_CLK_KHZ = 125000;
   localparam int TCSUP_MS_CYCLES = TCSUP_CLK_KHZ;

   // Interrupt bit positions.
   localparam int TCSUP_IRQ_RISE_BIT = 0;
   localparam int TCSUP_IRQ_FALL_BIT = 1;

   // AXI responses.
   localparam logic [1:0] TCSUP_RESP_OKAY   = 2'b00;
   localparam logic [1:0] TCSUP_RESP_SLVERR = 2'b10;

   // Wiring modes, one-hot, as field values 0..3 select them.
   typedef enum logic [3:0] {
      TCSUP_M1 = 4'b0001,
      TCSUP_M2 = 4'b0010,
      TCSUP_M3 = 4'b0100,
      TCSUP_M4 = 4'b1000
   } tcsup_mode_e;

endpackage

// ---- tb/tcsup_assertions.sv ----
// Port checker for the trip circuit supervisor.
`timescale 1ns/1ns
module tcsup_assertions #(
   parameter int MS_CYCLES = 10 // Clocks per millisecond.
) (
   input wire logic        i_core_clk, // Clock.
   input wire logic        i_rst, // Reset.
   input wire logic        i_breaker_open, // Open contact.
   input wire logic        i_breaker_closed, // Closed contact.
   input wire logic        i_supervision_input_a, // Sense a.
   input wire logic        i_supervision_input_b, // Sense b.
   input wire logic        o_wrong_position_alarm, // Alarm.
   input wire logic [7:0]  i_awaddr, // Write address.
   input wire logic        i_awvalid, // Address valid.
   input wire logic        o_awready, // Address ready.
   input wire logic [31:0] i_wdata, // Write data.
   input wire logic [3:0]  i_wstrb, // Strobes.
   input wire logic        i_wvalid, // Data valid.
   input wire logic        o_wready, // Data ready.
   input wire logic        o_bvalid, // Response valid.
   input wire logic        i_arvalid, // Read valid.
   input wire logic        o_arready, // Read ready.
   input wire logic [31:0] o_rdata, // Read data.
   input wire logic        o_rvalid, // Read data valid.
   input wire logic        i_rready // Read data taken.
);
   import tcsup_pkg::*;
   // ********************
   // Control shadow
   // ********************
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic       aw_q, aw_d, w_q, w_d, fire, en, pm, al, sa;
   logic [7:0] adr_q, adr_d;
   logic [4:0] dat_q, dat_d;
   logic [3:0] ctl_q, ctl_d;
   logic [1:0] md;
   // Collects both write halves; the write lands one edge after the last.
   always_comb begin
      aw_d  = aw_q | (i_awvalid & o_awready);
      w_d   = w_q | (i_wvalid & o_wready);
      adr_d = (i_awvalid & o_awready) ? i_awaddr : adr_q;
      dat_d = (i_wvalid & o_wready) ? {i_wstrb[0], i_wdata[3:0]} : dat_q;
      fire  = aw_q & w_q;
      ctl_d = ctl_q;
      if (fire && adr_q == TCSUP_CTRL_OFS && dat_q[4]) begin
         ctl_d = dat_q[3:0];
      end
      if (fire) begin
         aw_d = 1'h0;
         w_d  = 1'h0;
      end
   end
   // Registers the shadow state.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         {aw_q, w_q, adr_q, dat_q, ctl_q} <= '0;
      end else begin
         {aw_q, w_q, adr_q, dat_q, ctl_q} <= {aw_d, w_d, adr_d, dat_d, ctl_d};
      end
   end
   // Short names for the decoded control fields and watched pins.
   assign en = ctl_q[TCSUP_CTRL_EN_BIT];
   assign pm = ctl_q[TCSUP_CTRL_PERMIT_BIT];
   assign md = ctl_q[TCSUP_CTRL_MODE_LSB +: 2];
   assign al = o_wrong_position_alarm;
   assign sa = i_supervision_input_a;
   sequence s_read_taken;
      i_arvalid && o_arready;
   endsequence
   sequence s_read_stall;
      o_rvalid && !i_rready;
   endsequence
   chk_off_disabled:
      assert property (!en |=> !al) else $error("alarm while disabled");
   chk_m1_pair_ok:
      assert property (en && md == 2'h0 && (sa ^ i_supervision_input_b)
         |=> !al) else $error("alarm on valid pair");
   chk_m1_permit:
      assert property (en && md == 2'h0 && pm && sa && i_supervision_input_b
         |=> !al) else $error("alarm on permitted high pair");
   chk_m2_quiet:
      assert property (en && md == 2'h1 && (i_breaker_open || sa)
         |=> !al) else $error("mode two false alarm");
   chk_m3_quiet:
      assert property (en && md == 2'h2 && sa |=> !al)
         else $error("mode three false alarm");
   chk_m4_open:
      assert property (en && md == 2'h3 && i_breaker_open && !i_breaker_closed
         |=> !al) else $error("mode four alarm while open");
   chk_write_resp:
      assert property (fire |=> o_bvalid) else $error("no write response");
   chk_read_resp:
      assert property (s_read_taken |=> o_rvalid) else $error("no read data");
   chk_read_hold:
      assert property (s_read_stall |=> o_rvalid && $stable(o_rdata))
         else $error("read data dropped");
endmodule
bind tcsup_top tcsup_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_breaker_open(i_breaker_open),
   .i_breaker_closed(i_breaker_closed),
   .i_supervision_input_a(i_supervision_input_a),
   .i_supervision_input_b(i_supervision_input_b),
   .o_wrong_position_alarm(o_wrong_position_alarm), .i_awaddr(i_awaddr),
   .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
   .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
   .o_bvalid(o_bvalid), .i_arvalid(i_arvalid), .o_arready(o_arready),
   .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_rready(i_rready)
);

// ---- tb/tcsup_breaker_model.sv ----
// Model of breaker auxiliary contacts and trip circuit sense wiring.
`timescale 1ns/1ns
module tcsup_breaker_model (
   input  wire logic       i_clk, // Clock.
   input  wire logic [3:0] i_cmd, // Closed, open, coil a, coil b.
   output logic            o_open, // Open contact.
   output logic            o_closed, // Closed contact.
   output logic            o_sense_a, // Trip circuit sense a.
   output logic            o_sense_b // Trip circuit sense b.
);
   // ********************
   // Contacts
   // ********************
   // Contacts follow a command one edge later, as relay contacts lag.
   always_ff @(posedge i_clk) begin
      {o_closed, o_open, o_sense_a, o_sense_b} <= i_cmd;
   end
endmodule

// ---- tb/tcsup_top_tb_top.sv ----
// Self-checking bench for the trip circuit supervisor.
`timescale 1ns/1ns
module tcsup_top_tb_top;
   import tcsup_pkg::*;
   localparam int MS = 10; // Shortened millisecond.
   logic        clk = 1'h0, rst = 1'h1, bo, bc, sa, sb, alarm, irq;
   logic [3:0]  cmd = 4'h0; // Closed, open, a, b.
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, d, c0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, r;
   int          num_errors = 0, checks_done = 0, i;
   // Mode, contact command and expected alarm per row.
   logic [6:0]  tbl [17] = '{7'h01, 7'h02, 7'h07, 7'h04, 7'h31, 7'h34,
      7'h38, 7'h3c, 7'h41, 7'h44, 7'h68, 7'h6c, 7'h71, 7'h74, 7'h61,
      7'h79, 7'h7c};
   always #4 clk = ~clk;
   tcsup_breaker_model u_brk (.i_clk(clk), .i_cmd(cmd), .o_open(bo),
      .o_closed(bc), .o_sense_a(sa), .o_sense_b(sb));
   tcsup_top #(.MS_CYCLES(MS)) dut (.i_core_clk(clk), .i_rst(rst),
      .i_breaker_open(bo), .i_breaker_closed(bc),
      .i_supervision_input_a(sa), .i_supervision_input_b(sb),
      .o_wrong_position_alarm(alarm), .o_irq(irq), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
      .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready));
   // ********************
   // Tasks
   // ********************
   // Prints the counts and the verdict, then stops.
   task automatic give_verdict();
      $display("errors %0d, checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Counts a lost handshake and closes the run.
   task automatic tmo();
      num_errors++;
      give_verdict();
   endtask
   // Compares one result against its expected value.
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Writes one word; address and data go out together.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, w, ta, tw;
      int   n;
      aw = 1'h1;
      w = 1'h1;
      n = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while ((aw | w) && n < 200) begin
         @(negedge clk);
         ta = aw & awready;
         tw = w & wready;
         n++;
         @(posedge clk);
         if (ta) begin
            awvalid <= 1'h0;
            aw = 1'h0;
         end
         if (tw) begin
            wvalid <= 1'h0;
            w = 1'h0;
         end
      end
      bready <= 1'h1;
      do begin
         @(negedge clk);
         ta = bvalid;
         n++;
         @(posedge clk);
      end while (!ta && n < 400);
      bready <= 1'h0;
      if (!ta) tmo();
      cmp(bresp, TCSUP_RESP_OKAY);
   endtask
   // Reads one word and its response code.
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
      logic ok;
      int   n;
      n = 0;
      araddr <= a;
      arvalid <= 1'h1;
      do begin
         @(negedge clk);
         ok = arready;
         n++;
         @(posedge clk);
      end while (!ok && n < 200);
      arvalid <= 1'h0;
      rready <= 1'h1;
      do begin
         @(negedge clk);
         ok = rvalid;
         v = rdata;
         rs = rresp;
         n++;
         @(posedge clk);
      end while (!ok && n < 400);
      rready <= 1'h0;
      if (!ok) tmo();
   endtask
   // Reads and checks both data and response code.
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
      rd(a, d, r);
      cmp(d, e);
      cmp(r, er);
   endtask
   // Waits k cycles, then checks the alarm (sel 0) or interrupt (sel 1).
   task automatic look(input int k, input logic sel, input logic e);
      repeat (k) @(posedge clk);
      @(negedge clk);
      cmp(sel ? irq : alarm, e);
      @(posedge clk);
   endtask
   // Applies an invalid pattern and checks how long the alarm takes.
   task automatic meas(input logic [3:0] c, input int lo, input int hi);
      logic ok;
      int   n;
      n = 0;
      cmd <= c;
      do begin
         @(negedge clk);
         ok = alarm;
         n++;
         @(posedge clk);
      end while (!ok && n < 300);
      cmp(n, (n >= lo && n <= hi) ? n : lo);
   endtask
   // ********************
   // Sequence
   // ********************
   // Reset, defaults, timing, the mode table, events and disable.
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      rdc(TCSUP_CTRL_OFS, 32'h0, TCSUP_RESP_OKAY);
      rdc(TCSUP_LLDLY_OFS, 32'h3e8, TCSUP_RESP_OKAY);
      rdc(TCSUP_HHDLY_OFS, 32'h3e8, TCSUP_RESP_OKAY);
      rdc(TCSUP_COUNT_OFS, 32'h0, TCSUP_RESP_OKAY);
      rdc(8'h1c, 32'h0, TCSUP_RESP_SLVERR);
      wr(TCSUP_LLDLY_OFS, 32'hea61);
      rdc(TCSUP_LLDLY_OFS, 32'hea60, TCSUP_RESP_OKAY);
      wr(TCSUP_HHDLY_OFS, 32'h2711);
      rdc(TCSUP_HHDLY_OFS, 32'h2710, TCSUP_RESP_OKAY);
      wr(TCSUP_LLDLY_OFS, 32'h2);
      wr(TCSUP_HHDLY_OFS, 32'h4);
      cmd <= 4'h6;
      repeat (3) @(posedge clk);
      rdc(TCSUP_STAT_OFS, 32'h0a, TCSUP_RESP_OKAY);
      cmd <= 4'h2;
      wr(TCSUP_CTRL_OFS, 32'h5);
      meas(4'h0, 2 * MS - 1, 3 * MS + 4);
      cmd <= 4'h2;
      wr(TCSUP_CTRL_OFS, 32'h1);
      meas(4'h3, 4 * MS - 1, 5 * MS + 4);
      wr(TCSUP_CTRL_OFS, 32'h9);
      look(60, 1'h0, 1'h0);
      for (i = 0; i < 17; i++) begin
         wr(TCSUP_CTRL_OFS, {29'h0, tbl[i][6:5], 1'h1});
         cmd <= tbl[i][4:1];
         look(70, 1'h0, tbl[i][0]);
      end
      wr(TCSUP_CTRL_OFS, 32'h5);
      cmd <= 4'h2;
      wr(TCSUP_IRQMSK_OFS, 32'h1);
      rd(TCSUP_IRQST_OFS, d, r);
      rd(TCSUP_COUNT_OFS, c0, r);
      cmd <= 4'h0;
      look(40, 1'h1, 1'h1);
      rdc(TCSUP_IRQST_OFS, 32'h1, TCSUP_RESP_OKAY);
      look(3, 1'h1, 1'h0);
      cmd <= 4'h2;
      look(5, 1'h0, 1'h0);
      look(0, 1'h1, 1'h0);
      rdc(TCSUP_IRQST_OFS, 32'h2, TCSUP_RESP_OKAY);
      rdc(TCSUP_COUNT_OFS, c0 + 32'h1, TCSUP_RESP_OKAY);
      cmd <= 4'h0;
      look(40, 1'h0, 1'h1);
      wr(TCSUP_CTRL_OFS, 32'h4);
      look(1, 1'h0, 1'h0);
      wr(TCSUP_CTRL_OFS, 32'h5);
      look(12, 1'h0, 1'h0);
      look(20, 1'h0, 1'h1);
      give_verdict();
   end
endmodule
